// [ppo_monitor.sv]
// Watches the port's pins and registers; the enables are compared against their sources
module ppo_monitor #(parameter WIDTH = 8) (
  input             clock,
  input             rst,
  input             out_write,
  input             in_write,
  input             sleep_clamp,
  input             pullup_global_disable,
  input [WIDTH-1:0] write_data,
  input [WIDTH-1:0] ext_int_enabled,
  input [WIDTH-1:0] ext_int_edge_mode,
  input [WIDTH-1:0] pullup_override_en,
  input [WIDTH-1:0] pullup_override_val,
  input [WIDTH-1:0] direction_override_en,
  input [WIDTH-1:0] direction_override_val,
  input [WIDTH-1:0] out_value_override_en,
  input [WIDTH-1:0] out_value_override_val,
  input [WIDTH-1:0] out_toggle_override_en,
  input [WIDTH-1:0] input_enable_override_en,
  input [WIDTH-1:0] input_enable_override_val,
  input [WIDTH-1:0] pad_in,
  input [WIDTH-1:0] pad_out,
  input [WIDTH-1:0] pad_oe,
  input [WIDTH-1:0] pad_pullup,
  input [WIDTH-1:0] pin_direction_bit,
  input [WIDTH-1:0] pin_output_bit,
  input [WIDTH-1:0] pin_input_bit,
  input [WIDTH-1:0] ext_int_flag_set
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pad level after the sleep clamp; interrupt pins escape the clamp
  wire [WIDTH-1:0] gated = pad_in & (input_enable_override_en & input_enable_override_val
    | ~input_enable_override_en & (ext_int_enabled | {WIDTH{~sleep_clamp}}));
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Inputs held one cycle, so registered outputs must have caught up
  a_driver_enable: assert property ($stable({direction_override_en,
    direction_override_val, pin_direction_bit}) |-> pad_oe == (direction_override_en
    & direction_override_val | ~direction_override_en & pin_direction_bit)) else $error("driver enable wrong");
  a_drive_value: assert property ($stable({out_value_override_en,
    out_value_override_val, pin_output_bit}) |-> pad_out == (pad_oe & (out_value_override_en
    & out_value_override_val | ~out_value_override_en & pin_output_bit))) else $error("drive value wrong");
  // The pull-up lags reset release by one extra edge, hence two quiet edges first
  a_pullup_source: assert property (!$past(rst) && !$past(rst, 2) && $stable({
    pullup_override_en, pullup_override_val, pin_direction_bit, pin_output_bit, pullup_global_disable})
    |-> pad_pullup == (pullup_override_en & pullup_override_val | ~pullup_override_en
    & ~pin_direction_bit & pin_output_bit & {WIDTH{~pullup_global_disable}})) else $error("pull-up wrong");
  a_pullup_reset: assert property (disable iff (1'b0) rst [*2] |-> pad_pullup == '0)
    else $error("pull-up on in reset");
  a_output_register: assert property (!out_write |-> ##2 pin_output_bit == ($past(pin_output_bit)
    ^ $past(out_toggle_override_en, 2) ^ ($past(write_data, 2) & {WIDTH{$past(in_write, 2)}})))
    else $error("output register update wrong");
  a_input_sync: assert property ($stable({pad_in, sleep_clamp, ext_int_enabled,
    input_enable_override_en, input_enable_override_val}) [*3] |-> pin_input_bit == gated)
    else $error("synchronised input wrong");
  a_wake_flag: assert property ($fell(sleep_clamp) && $stable(pad_in) |-> ##[1:3]
    ext_int_flag_set == (ext_int_edge_mode & ~ext_int_enabled & ~input_enable_override_en & pad_in))
    else $error("wake flag wrong");
  a_flag_origin: assert property (|ext_int_flag_set |-> $past(sleep_clamp)
    || $past(sleep_clamp, 2) || $past(sleep_clamp, 3)) else $error("flag without wake");
endmodule

bind ppo_port ppo_monitor #(.WIDTH(WIDTH)) mon (.*);

// [ppo_pad_model.sv]
// Pad and outside world: design driver first, then outside source, then pull-up
module ppo_pad_model #(parameter WIDTH = 8) (
  input              clock,
  input  [WIDTH-1:0] pad_out,
  input  [WIDTH-1:0] pad_oe,
  input  [WIDTH-1:0] pad_pullup,
  input  [WIDTH-1:0] ext_en,
  input  [WIDTH-1:0] ext_val,
  output [WIDTH-1:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // A floating pad flips every cycle so a stale level never reads as good
  logic [WIDTH-1:0] wander_q = '0;
  always @(posedge clock) wander_q <= ~wander_q;
  assign pad_in = pad_oe & pad_out | ~pad_oe & ext_en & ext_val
    | ~pad_oe & ~ext_en & (pad_pullup | wander_q);
endmodule

// [ppo_pin.v]
`include "ppo_regs.vh"
// One pin slice: the pad-facing combinational control paths
module ppo_pin (
  input  wire pin_direction_bit,         // Direction register bit
  input  wire pin_output_bit,            // Output register bit
  input  wire pullup_global_disable,     // Shared pull-up disable
  input  wire in_reset,                  // Reset active
  input  wire sleep_clamp,               // Sleep controller clamp request
  input  wire ext_int_enabled,           // External interrupt enabled on this pin
  input  wire pullup_override_en,
  input  wire pullup_override_val,
  input  wire direction_override_en,
  input  wire direction_override_val,
  input  wire out_value_override_en,
  input  wire out_value_override_val,
  input  wire input_enable_override_en,
  input  wire input_enable_override_val,
  input  wire pad_in,                    // Raw pad level
  output wire pull_en,                   // Pull-up enable
  output wire drive_en,                  // Output driver enable
  output wire drive_val,                 // Value driven
  output wire input_gated                // Schmitt input after clamp
);
  wire reg_pull;                          // Register-requested pull-up
  wire in_en;                             // Digital input enable

  // Pull-up from register pattern unless overridden; reset always wins
  assign reg_pull = ({pin_direction_bit, pin_output_bit, pullup_global_disable}
                     == `PPO_PULLUP_PATTERN); // RULE6 RULE18 RULE19
  assign pull_en  = ~in_reset &
                    (pullup_override_en ? pullup_override_val : reg_pull); // RULE4 RULE7

  // Driver enable from direction bit or its override
  assign drive_en  = direction_override_en ? direction_override_val
                                           : pin_direction_bit; // RULE8 RULE9 RULE18
  // Driven value from output bit or its override
  assign drive_val = out_value_override_en ? out_value_override_val
                                           : pin_output_bit; // RULE10 RULE11

  // Clamp in deep sleep except for interrupt pins; override decides when set
  assign in_en = input_enable_override_en ? input_enable_override_val
                                          : ~(sleep_clamp & ~ext_int_enabled); // RULE1 RULE2 RULE13 RULE14
  // Forcing low ahead of the trigger keeps a floating pad from burning current
  assign input_gated = in_en & pad_in; // RULE1
endmodule

// [ppo_port.v]
// Behaviour
// RULE1 - Sleep clamp grounds the digital input path
// RULE2 - Interrupt-enabled pins escape the sleep clamp
// RULE3 - Clamp release on high pin sets flag
// RULE4 - Pull-up forced off during reset
// RULE5 - Software gives unused pins defined levels
// RULE6 - Pull-up when pattern equals 010
// RULE7 - Pull-up override value decides when enabled
// RULE8 - Driver enable from direction or override
// RULE9 - Direction override value switches driver
// RULE10 - Driven value from output bit or override
// RULE11 - Value override replaces output bit
// RULE12 - Toggle override inverts output bit
// RULE13 - Input enable from sleep state or override
// RULE14 - Input enable override value decides
// RULE15 - Alternate input tapped before synchronizer
// RULE16 - Analog line straight from pad
// RULE17 - Strobes shared per port, clamp global
// RULE18 - Direction one output, zero input
// RULE19 - Global disable kills all pull-ups; an enabled pull-up override still turns one on here
// RULE20 - Writing one to input bit toggles output
// RULE21 - Latch then register before input bit; here two registers, the first standing in for the latch
// RULE22 - Overrides inactive after reset
`include "ppo_regs.vh"
module ppo_port #(
  parameter WIDTH = `PPO_PORT_WIDTH         // Pins in this port
) (
  input  wire             clock,                      // I/O clock, shared by all ports
  input  wire             rst,                        // Async reset, active high
  input  wire             dir_write,                  // Direction register write strobe
  input  wire             out_write,                  // Output register write strobe
  input  wire             in_write,                   // Input register write (toggle) strobe
  input  wire [WIDTH-1:0] write_data,                 // Data for the write strobes
  input  wire             pullup_global_disable_write, // Global disable write strobe
  input  wire             pullup_global_disable_data, // Global disable write data
  input  wire             sleep_clamp,                // Deep-sleep clamp request
  input  wire [WIDTH-1:0] ext_int_enabled,            // External interrupt enables
  input  wire [WIDTH-1:0] ext_int_edge_mode,          // Pin set for edge/any-change sense
  input  wire [WIDTH-1:0] pullup_override_en,
  input  wire [WIDTH-1:0] pullup_override_val,
  input  wire [WIDTH-1:0] direction_override_en,
  input  wire [WIDTH-1:0] direction_override_val,
  input  wire [WIDTH-1:0] out_value_override_en,
  input  wire [WIDTH-1:0] out_value_override_val,
  input  wire [WIDTH-1:0] out_toggle_override_en,
  input  wire [WIDTH-1:0] input_enable_override_en,
  input  wire [WIDTH-1:0] input_enable_override_val,
  input  wire [WIDTH-1:0] pad_in,                     // Pad levels
  output reg  [WIDTH-1:0] pad_out,                    // Pad drive value
  output reg  [WIDTH-1:0] pad_oe,                     // Pad driver enable, high drives
  output reg  [WIDTH-1:0] pad_pullup,                 // Pull-up enable
  output reg  [WIDTH-1:0] schmitt_output_tap,         // Unsynchronised input for peripherals
  output reg  [WIDTH-1:0] analog_pad_line,            // Pad level for analog users
  output reg  [WIDTH-1:0] pin_direction_bit,          // Direction register
  output reg  [WIDTH-1:0] pin_output_bit,             // Output register
  output reg  [WIDTH-1:0] pin_input_bit,              // Synchronised pin value
  output reg              pullup_global_disable,      // Global pull-up disable bit
  output reg  [WIDTH-1:0] ext_int_flag_set            // Pulse: sleep-release edge seen
);
  reg  [WIDTH-1:0] dir_q;                  // Direction bits
  reg  [WIDTH-1:0] out_q;                  // Output bits
  reg  [WIDTH-1:0] out_d;                  // Next output bits
  reg              gpud_q;                 // Global pull-up disable
  reg  [WIDTH-1:0] sync_q;                 // Sync stage standing in for the latch
  reg  [WIDTH-1:0] gated_prev_q;           // Gated input last cycle
  reg              clamp_prev_q;           // Clamp request last cycle
  reg              in_reset_q;             // Reset seen, drops one edge after release
  wire [WIDTH-1:0] pull_w;                 // Per-pin pull-up
  wire [WIDTH-1:0] oe_w;                   // Per-pin driver enable
  wire [WIDTH-1:0] val_w;                  // Per-pin drive value
  wire [WIDTH-1:0] gated_w;                // Per-pin gated input

  genvar g;
  // One slice per pin; strobes and global controls fan out to all
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : pin_slice
      ppo_pin u_pin (
        .pin_direction_bit        (dir_q[g]),
        .pin_output_bit           (out_q[g]),
        .pullup_global_disable    (gpud_q),         // RULE17
        .in_reset                 (in_reset_q),
        .sleep_clamp              (sleep_clamp),    // RULE17
        .ext_int_enabled          (ext_int_enabled[g]),
        .pullup_override_en       (pullup_override_en[g]),
        .pullup_override_val      (pullup_override_val[g]),
        .direction_override_en    (direction_override_en[g]),
        .direction_override_val   (direction_override_val[g]),
        .out_value_override_en    (out_value_override_en[g]),
        .out_value_override_val   (out_value_override_val[g]),
        .input_enable_override_en (input_enable_override_en[g]),
        .input_enable_override_val(input_enable_override_val[g]),
        .pad_in                   (pad_in[g]),
        .pull_en                  (pull_w[g]),
        .drive_en                 (oe_w[g]),
        .drive_val                (val_w[g]),
        .input_gated              (gated_w[g])
      );
    end
  endgenerate

  // Output register next value: write, then toggle sources
  always @* begin
    out_d = out_q;
    // Plain write from the shared port strobe
    if (out_write) begin
      out_d = write_data; // RULE17
    end
    // Writing one to the input register flips the bit, direction ignored
    if (in_write) begin
      out_d = out_d ^ write_data; // RULE20
    end
    // Peripheral toggle request inverts the bit
    out_d = out_d ^ out_toggle_override_en; // RULE12
  end

  // Reset flag held while reset is high; pull-ups stay off until it drops
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      in_reset_q <= 1'h1; // RULE4
    end else begin
      in_reset_q <= 1'h0;
    end
  end

  // Register bits; overrides are inputs, so the port relies on
  // peripherals holding them low out of reset
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      dir_q  <= {WIDTH{`PPO_DIR_RST}};  // RULE22
      out_q  <= {WIDTH{`PPO_OUT_RST}};  // RULE22
      gpud_q <= `PPO_GPUD_RST;          // RULE19
    end else begin
      out_q <= out_d;
      // Direction write from the shared strobe
      if (dir_write) begin
        dir_q <= write_data; // RULE17 RULE18
      end
      // Global disable is one bit per port, common to every pin of this port
      if (pullup_global_disable_write) begin
        gpud_q <= pullup_global_disable_data; // RULE19
      end
    end
  end

  // Two-stage input path: first stage replaces the transparent-high latch
  // in this single-edge design, so delay is two edges, not half to one and a half
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_q        <= {WIDTH{1'h0}};
      pin_input_bit <= {WIDTH{1'h0}};
    end else begin
      sync_q        <= gated_w;         // RULE21
      pin_input_bit <= sync_q;          // RULE21
    end
  end

  // Clamp release on a high pin looks like a rising edge to the sensor
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      clamp_prev_q     <= 1'h0;
      gated_prev_q     <= {WIDTH{1'h0}};
      ext_int_flag_set <= {WIDTH{1'h0}};
    end else begin
      clamp_prev_q     <= sleep_clamp;
      gated_prev_q     <= gated_w;
      ext_int_flag_set <= {WIDTH{clamp_prev_q & ~sleep_clamp}} & ~ext_int_enabled &
                          ext_int_edge_mode & ~gated_prev_q & gated_w; // RULE3
    end
  end

  // Registered pad and peripheral outputs
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pad_out               <= {WIDTH{1'h0}};
      pad_oe                <= {WIDTH{1'h0}};
      pad_pullup            <= {WIDTH{1'h0}};
      schmitt_output_tap    <= {WIDTH{1'h0}};
      analog_pad_line       <= {WIDTH{1'h0}};
      pin_direction_bit     <= {WIDTH{1'h0}};
      pin_output_bit        <= {WIDTH{1'h0}};
      pullup_global_disable <= 1'h0;
    end else begin
      pad_oe                <= oe_w;                    // RULE8 RULE9
      pad_out               <= oe_w & val_w;            // RULE10 RULE11
      pad_pullup            <= pull_w & ~{WIDTH{in_reset_q}}; // RULE4 RULE6 RULE7
      schmitt_output_tap    <= gated_w;                 // RULE15
      // Digital copy only; a true analog path lives outside this logic
      analog_pad_line       <= pad_in;                  // RULE16
      pin_direction_bit     <= dir_q;
      pin_output_bit        <= out_q;
      pullup_global_disable <= gpud_q;
    end
  end
endmodule

// [ppo_regs.vh]
`ifndef PPO_REGS_VH
`define PPO_REGS_VH
// Pull-up enable pattern for {direction, output, global disable}
`define PPO_PULLUP_PATTERN 3'h2
// Reset values of the per-pin direction and output bits and the global disable bit
`define PPO_DIR_RST        1'h0
`define PPO_OUT_RST        1'h0
`define PPO_GPUD_RST       1'h0
// Default pin count of one port
`define PPO_PORT_WIDTH     8
`endif

// [test_port_pin_override_logic.sv]
module test_port_pin_override_logic;
  timeunit 1ns;
  timeprecision 1ns;
  localparam W = 8;
  `define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
  logic clock = 0, rst = 1, dir_write = 0, out_write = 0, in_write = 0, sleep_clamp = 0;
  logic pullup_global_disable_write = 0, pullup_global_disable_data = 0, gpud_m = 0;
  logic [W-1:0] write_data = 0, ext_int_enabled = 0, ext_int_edge_mode = 0, ext_en = 0, ext_val = 0;
  logic [W-1:0] pullup_override_en = 0, pullup_override_val = 0, direction_override_en = 0;
  logic [W-1:0] direction_override_val = 0, out_value_override_en = 0, out_value_override_val = 0;
  logic [W-1:0] out_toggle_override_en = 0, input_enable_override_en = 0, input_enable_override_val = 0;
  wire  [W-1:0] pad_in, pad_out, pad_oe, pad_pullup, schmitt_output_tap, analog_pad_line;
  wire  [W-1:0] pin_direction_bit, pin_output_bit, pin_input_bit, ext_int_flag_set;
  wire          pullup_global_disable;
  logic [W-1:0] dir_m = 0, out_m = 0, oe, val, pu, pad, msk, ie, acc;
  int           failures = 0, cmp_count = 0, cyc = 0, i;
  ppo_port #(.WIDTH(W)) uut (.*);
  ppo_pad_model #(.WIDTH(W)) pad_m (.*);
  always #25 clock = ~clock;
  // Hang guard: the whole run needs well under two thousand cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc > 5000) begin
      failures++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One-cycle write strobe: 0 direction, 1 output, 2 input (toggle), 3 global disable
  task wr(input int k, input [W-1:0] d);
    @(posedge clock) #2;
    write_data = d;
    pullup_global_disable_data = d[0];
    {dir_write, out_write, in_write, pullup_global_disable_write} = 4'h8 >> k;
    case (k)
      0: dir_m = d;
      1: out_m = d;
      2: out_m ^= d;
      default: gpud_m = d[0];
    endcase
    @(posedge clock) #2 {dir_write, out_write, in_write, pullup_global_disable_write} = 4'h0;
  endtask
  // Let all pipelines settle, then compare every output except ext_int_flag_set with the bench model
  task chk;
    repeat (5) @(posedge clock);
    #2;
    oe  = direction_override_en & direction_override_val | ~direction_override_en & dir_m;
    val = out_value_override_en & out_value_override_val | ~out_value_override_en & out_m;
    pu  = pullup_override_en & pullup_override_val
        | ~pullup_override_en & ~dir_m & out_m & {W{~gpud_m}};
    pad = oe & val | ~oe & ext_en & ext_val | ~oe & ~ext_en & pu;
    msk = oe | ext_en | pu; // Floating pins are unknowable, so masked
    ie  = input_enable_override_en & input_enable_override_val
        | ~input_enable_override_en & (ext_int_enabled | {W{~sleep_clamp}});
    `CHK(pin_direction_bit, dir_m)
    `CHK(pin_output_bit, out_m)
    `CHK(pullup_global_disable, gpud_m)
    `CHK(pad_oe, oe)
    `CHK(pad_out, oe & val)
    `CHK(pad_pullup, pu)
    `CHK(pin_input_bit & msk, pad & ie)
    `CHK(schmitt_output_tap & msk, pad & ie)
    `CHK(analog_pad_line & msk, pad)
  endtask
  initial begin
    void'($urandom(32'h2FEBFD74));
    pullup_override_en = '1;
    pullup_override_val = '1;
    repeat (12) @(posedge clock);
    `CHK(pad_pullup, 8'h00)
    #2 rst = 0;
    {pullup_override_en, pullup_override_val} = '0;
    chk;
    $display("reset test done");
    ext_en = '1;
    ext_val = '1;
    for (i = 0; i < 3; i++) begin
      ext_int_edge_mode = W'($urandom);
      ext_int_enabled = W'($urandom);
      sleep_clamp = 1;
      chk;
      sleep_clamp = 0;
      acc = '0;
      repeat (4) @(posedge clock) #1 acc |= ext_int_flag_set;
      `CHK(acc, ext_int_edge_mode & ~ext_int_enabled)
    end
    ext_int_edge_mode = '0;
    $display("wake test done");
    for (i = 0; i < 48; i++) begin
      wr($urandom_range(0, 3), W'($urandom));
      {direction_override_en, out_value_override_en, pullup_override_en,
       input_enable_override_en} = $urandom & $urandom;
      {direction_override_val, out_value_override_val, pullup_override_val,
       input_enable_override_val} = $urandom;
      ext_en = i[0] ? '1 : W'($urandom);
      ext_val = W'($urandom);
      ext_int_enabled = W'($urandom);
      sleep_clamp = ($urandom_range(0, 3) == 0);
      out_toggle_override_en = W'($urandom);
      out_m ^= out_toggle_override_en;
      @(posedge clock) #2 out_toggle_override_en = '0;
      chk;
    end
    $display("override test done");
    {direction_override_en, out_value_override_en, pullup_override_en, input_enable_override_en} = '0;
    {sleep_clamp, ext_en} = '0;
    for (i = 0; i < 8; i++) begin
      wr(0, {W{i[2]}});
      wr(1, {W{i[1]}});
      wr(3, {W{i[0]}});
      chk;
    end
    $display("pattern test done");
    tally_and_finish();
  end
endmodule
